// ===== logic/fra_consts.svh
// Function
// RULE1: Flash registers answer only while the select bit is 1; RAM emulation is never gated.
// RULE2: The select bit maps the shared addresses FFC8 to FFCB onto the four flash registers.
// RULE3: In modes with flash disabled, flash register reads return zero and writes are dropped.
// RULE4: Flash register writes are dropped while the permit bit of control one reads 0.
// RULE5: Control register one starts at 80 while the permit pin is high and at 00 otherwise.
// RULE6: Control two and the erase-block registers stay zero while pin or software permit is off.
// RULE7: The four flash registers are byte-wide and take byte accesses only.
// RULE8: Each byte access to a flash register takes two bus states.
// RULE9: Without reprogrammable flash, system control two ignores writes and reads undefined.
// RULE10: The permit pin protects the flash from programming and erasure whenever it is low.
// RULE11: Three mode pins select the operating mode; in programmer mode three port pins also do.
// RULE12: During programming serial data leave on the channel-1 output and enter on its input.
// RULE13: In user mode software checks the pin, then copies the routine to RAM and runs it.
// RULE14: Erasure sets contents to FF and works on whole blocks only.
// RULE15: Software programs only blocks that were erased before.
// RULE16: Each bit of the erase-block registers selects one block for the next erase.
`ifndef FRA_CONSTS_SVH
`define FRA_CONSTS_SVH

// ==================================================================
// Register map
`define FRA_ADDR_RAM_EMU     16'hFEDB
`define FRA_ADDR_SYS_CTRL2   16'hFF42
`define FRA_ADDR_FL_CTRL1    16'hFFC8
`define FRA_ADDR_FL_CTRL2    16'hFFC9
`define FRA_ADDR_ERASE_SEL1  16'hFFCA
`define FRA_ADDR_ERASE_SEL2  16'hFFCB

// ==================================================================
// Fields and values
`define FRA_SEL_BIT          3
`define FRA_HW_PERMIT_BIT    7
`define FRA_SW_PERMIT_BIT    6
`define FRA_PROG_BIT         0
`define FRA_ERASE_BIT        1
`define FRA_HW_PERMIT_MASK   8'h80
`define FRA_RESET_VAL        8'h00
`define FRA_UNDEF_READ       8'hA5
`define FRA_ERASED_BYTE      8'hFF
`define FRA_SERIAL_IDLE      1'h1

// ==================================================================
// Operating modes with flash enabled
`define FRA_MODE_PROGRAMMER  3'h0
`define FRA_MODE_ROM_EXP     3'h6
`define FRA_MODE_ROM_SINGLE  3'h7

`endif

// ===== logic/fra_pin_if.sv
`timescale 1ns/10ps
interface fra_pin_if;
  logic [2:0] mode_s;
  logic [2:0] prog_s;
  logic       permit_s;
  logic       rxd_s;
  logic       flash_on;

  modport sync (output mode_s, prog_s, permit_s, rxd_s, flash_on);
  modport core (input mode_s, prog_s, permit_s, rxd_s, flash_on);
endinterface // fra_pin_if

// ===== logic/fra_pin_sync.sv
`timescale 1ns/10ps
module fra_pin_sync
  import fra_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [2:0]  mode_pins,
  input  wire logic [2:0]  prog_pins,
  input  wire logic        permit_pin,
  input  wire logic        rxd_pin,
  fra_pin_if.sync          pins
);
  import fra_pkg::*;

  fra_sync_t sy_reg;
  fra_sync_t sy_next;

  // ==================================================================
  // Two-stage synchronisers; stage one feeds stage two only
  always_comb begin
    sy_next           = sy_reg;
    sy_next.mode_s1   = mode_pins;
    sy_next.mode_s2   = sy_reg.mode_s1;
    sy_next.prog_s1   = prog_pins;
    sy_next.prog_s2   = sy_reg.prog_s1;
    sy_next.permit_s1 = permit_pin;
    sy_next.permit_s2 = sy_reg.permit_s1;
    sy_next.rxd_s1    = rxd_pin;
    sy_next.rxd_s2    = sy_reg.rxd_s1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // Permit held low: flash protected until the pin is seen
      sy_reg <= '{default: 1'b0, rxd_s1: 1'b1, rxd_s2: 1'b1};
    end else begin
      sy_reg <= sy_next;
    end
  end

  // RULE11 mode pin decode
  assign pins.mode_s   = sy_reg.mode_s2;
  assign pins.prog_s   = sy_reg.prog_s2;
  assign pins.permit_s = sy_reg.permit_s2;
  assign pins.rxd_s    = sy_reg.rxd_s2;
  assign pins.flash_on = fra_flash_mode(sy_reg.mode_s2);
endmodule // fra_pin_sync

// ===== logic/fra_pkg.sv
package fra_pkg;
  `include "fra_consts.svh"

  typedef enum logic [1:0] {
    FRA_ACC_IDLE   = 2'b01,
    FRA_ACC_STATE2 = 2'b10
  } fra_acc_t;

  typedef struct packed {
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic [2:0] prog_s1;
    logic [2:0] prog_s2;
    logic       permit_s1;
    logic       permit_s2;
    logic       rxd_s1;
    logic       rxd_s2;
  } fra_sync_t;

  typedef struct packed {
    fra_acc_t    acc;
    logic        pend_wr;
    logic [1:0]  pend_idx;
    logic [7:0]  pend_data;
    logic [7:0]  ram_emu;
    logic [7:0]  sys_ctrl2;
    logic [7:0]  fl_ctrl1;
    logic [7:0]  fl_ctrl2;
    logic [7:0]  erase_sel1;
    logic [7:0]  erase_sel2;
    logic [7:0]  rdata;
    logic        acc_done;
    logic        prog_en;
    logic        erase_en;
    logic [15:0] erase_mask;
    logic [7:0]  erase_fill;
    logic        ser_out;
    logic        sci_rx;
    logic [5:0]  mode_code;
  } fra_state_t;

  function automatic logic fra_flash_mode(input logic [2:0] mode);
    return (mode == `FRA_MODE_PROGRAMMER) || (mode == `FRA_MODE_ROM_EXP) ||
           (mode == `FRA_MODE_ROM_SINGLE);
  endfunction

  function automatic logic fra_flash_addr(input logic [15:0] addr);
    return (addr >= `FRA_ADDR_FL_CTRL1) && (addr <= `FRA_ADDR_ERASE_SEL2);
  endfunction
endpackage

// ===== logic/fra_top.sv
`timescale 1ns/10ps
module fra_top
  import fra_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wide,
  output logic      [7:0]  bus_rdata,
  output logic             acc_done,
  input  wire logic        flash_write_permit,
  input  wire logic        op_mode_pin_2,
  input  wire logic        op_mode_pin_1,
  input  wire logic        op_mode_pin_0,
  input  wire logic        programmer_mode_pin_c,
  input  wire logic        programmer_mode_pin_b,
  input  wire logic        programmer_mode_pin_a,
  input  wire logic        serial_in_ch1,
  output logic             serial_out_ch1,
  input  wire logic        sci_tx_data,
  output logic             sci_rx_data,
  output logic             flash_prog_en,
  output logic             flash_erase_en,
  output logic      [15:0] erase_block_mask,
  output logic      [7:0]  erase_fill,
  output logic      [5:0]  op_mode_code
);
  import fra_pkg::*;

  localparam fra_state_t ST_RESET = '{
    acc:        FRA_ACC_IDLE,
    ser_out:    `FRA_SERIAL_IDLE,
    sci_rx:     `FRA_SERIAL_IDLE,
    default:    '0
  };

  fra_pin_if  pins ();
  fra_state_t st_reg;
  fra_state_t st_next;

  logic flash_hit;
  logic hw_permit;
  logic sw_permit;

  fra_pin_sync u_sync (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .mode_pins  ({op_mode_pin_2, op_mode_pin_1, op_mode_pin_0}),
    .prog_pins  ({programmer_mode_pin_c, programmer_mode_pin_b, programmer_mode_pin_a}),
    .permit_pin (flash_write_permit),
    .rxd_pin    (serial_in_ch1),
    .pins       (pins.sync)
  );

  // ==================================================================
  // Address decode
  // RULE1 select gating
  // RULE7 byte access only
  assign flash_hit = st_reg.sys_ctrl2[`FRA_SEL_BIT] && fra_flash_addr(bus_addr) && !bus_wide;
  assign hw_permit = pins.permit_s;

  // ==================================================================
  // Next-state logic
  always_comb begin
    st_next          = st_reg;
    st_next.rdata    = `FRA_RESET_VAL;
    st_next.acc_done = 1'b0;
    sw_permit        = 1'b0;

    // RULE8 second state commits
    if (st_reg.acc == FRA_ACC_STATE2) begin
      st_next.acc      = FRA_ACC_IDLE;
      st_next.acc_done = 1'b1;
      // RULE4 permit bit gates writes
      if (st_reg.pend_wr && st_reg.fl_ctrl1[`FRA_HW_PERMIT_BIT] && pins.flash_on) begin
        case (st_reg.pend_idx)
          2'h0:    st_next.fl_ctrl1   = st_reg.pend_data;
          2'h1:    st_next.fl_ctrl2   = st_reg.pend_data;
          2'h2:    st_next.erase_sel1 = st_reg.pend_data;
          2'h3:    st_next.erase_sel2 = st_reg.pend_data;
          default: st_next.fl_ctrl1   = st_reg.fl_ctrl1;
        endcase
      end
    end

    if (bus_wr) begin
      if (bus_addr == `FRA_ADDR_RAM_EMU) begin
        st_next.ram_emu = bus_wdata;
      end
      // RULE9 variant without flash
      if (bus_addr == `FRA_ADDR_SYS_CTRL2 && HAS_FLASH) begin
        st_next.sys_ctrl2 = bus_wdata;
      end
      // RULE2 shared address mapping
      if (flash_hit) begin
        st_next.acc       = FRA_ACC_STATE2;
        st_next.pend_wr   = 1'b1;
        st_next.pend_idx  = bus_addr[1:0];
        st_next.pend_data = bus_wdata;
      end
    end

    if (bus_rd) begin
      if (bus_addr == `FRA_ADDR_RAM_EMU) begin
        st_next.rdata = st_reg.ram_emu;
      end
      if (bus_addr == `FRA_ADDR_SYS_CTRL2) begin
        st_next.rdata = HAS_FLASH ? st_reg.sys_ctrl2 : `FRA_UNDEF_READ;
      end
      if (flash_hit) begin
        st_next.acc     = FRA_ACC_STATE2;
        st_next.pend_wr = 1'b0;
        // RULE3 disabled mode reads zero
        if (pins.flash_on) begin
          case (bus_addr[1:0])
            2'h0:    st_next.rdata = st_reg.fl_ctrl1;
            2'h1:    st_next.rdata = st_reg.fl_ctrl2;
            2'h2:    st_next.rdata = st_reg.erase_sel1;
            2'h3:    st_next.rdata = st_reg.erase_sel2;
            default: st_next.rdata = `FRA_RESET_VAL;
          endcase
        end
      end
    end

    // RULE5 permit bit mirrors pin
    st_next.fl_ctrl1[`FRA_HW_PERMIT_BIT] = hw_permit;
    if (!hw_permit) begin
      st_next.fl_ctrl1 = `FRA_RESET_VAL;
    end
    sw_permit = st_next.fl_ctrl1[`FRA_SW_PERMIT_BIT];

    // RULE6 hold at zero
    if (!hw_permit || !sw_permit) begin
      st_next.fl_ctrl2   = `FRA_RESET_VAL;
      st_next.erase_sel1 = `FRA_RESET_VAL;
      st_next.erase_sel2 = `FRA_RESET_VAL;
    end

    // RULE10 pin protection
    st_next.prog_en  = hw_permit && sw_permit && pins.flash_on &&
                       st_next.fl_ctrl1[`FRA_PROG_BIT];
    st_next.erase_en = hw_permit && sw_permit && pins.flash_on &&
                       st_next.fl_ctrl1[`FRA_ERASE_BIT] && !st_next.fl_ctrl1[`FRA_PROG_BIT];

    // RULE16 one bit per block
    // RULE14 whole blocks to FF
    st_next.erase_mask = st_next.erase_en ? {st_next.erase_sel2, st_next.erase_sel1} : 16'h0000;
    st_next.erase_fill = st_next.erase_en ? `FRA_ERASED_BYTE : `FRA_RESET_VAL;

    // RULE12 serial channel one
    st_next.ser_out   = pins.flash_on ? sci_tx_data : `FRA_SERIAL_IDLE;
    st_next.sci_rx    = pins.rxd_s;
    // RULE11 mode reported
    st_next.mode_code = {pins.prog_s, pins.mode_s};
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==================================================================
  // Outputs
  assign bus_rdata        = st_reg.rdata;
  assign acc_done         = st_reg.acc_done;
  assign serial_out_ch1   = st_reg.ser_out;
  assign sci_rx_data      = st_reg.sci_rx;
  assign flash_prog_en    = st_reg.prog_en;
  assign flash_erase_en   = st_reg.erase_en;
  assign erase_block_mask = st_reg.erase_mask;
  assign erase_fill       = st_reg.erase_fill;
  assign op_mode_code     = st_reg.mode_code;

  // ==================================================================
  // Assertions
  a_select_gate_read: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
    bus_rd && fra_flash_addr(bus_addr) && !st_reg.sys_ctrl2[`FRA_SEL_BIT] |=> bus_rdata == 8'h00)
    else $error("flash register read while deselected");

  a_select_map_read: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
    bus_rd && flash_hit && pins.flash_on && bus_addr == `FRA_ADDR_FL_CTRL1
    |=> bus_rdata == $past(st_reg.fl_ctrl1))
    else $error("control register one not mapped");

  a_disabled_reads_zero: assert property (@(posedge mclk) disable iff (!rst_b) // RULE3
    bus_rd && flash_hit && !pins.flash_on |=> bus_rdata == 8'h00)
    else $error("flash register read nonzero in disabled mode");

  // Pin may already be up at the commit edge; the drop must still hold
  a_write_blocked: assert property (@(posedge mclk) disable iff (!rst_b) // RULE4
    st_reg.acc == FRA_ACC_STATE2 && st_reg.pend_wr && !st_reg.fl_ctrl1[`FRA_HW_PERMIT_BIT]
    |=> st_reg.fl_ctrl1[6:0] == 7'h00)
    else $error("write taken without permit");

  a_permit_mirror: assert property (@(posedge mclk) disable iff (!rst_b) // RULE5
    1'b1 |=> st_reg.fl_ctrl1[`FRA_HW_PERMIT_BIT] == $past(hw_permit))
    else $error("control register one permit bit wrong");

  a_hold_zero: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
    !hw_permit |=> st_reg.fl_ctrl1 == 8'h00 && st_reg.fl_ctrl2 == 8'h00 &&
    st_reg.erase_sel1 == 8'h00 && st_reg.erase_sel2 == 8'h00)
    else $error("flash registers not held at zero");

  a_wide_refused: assert property (@(posedge mclk) disable iff (!rst_b) // RULE7
    bus_rd && bus_wide && fra_flash_addr(bus_addr) |=> bus_rdata == 8'h00 ##1 !acc_done)
    else $error("wide access answered");

  // Back-to-back accesses overlap the previous done pulse
  a_two_states: assert property (@(posedge mclk) disable iff (!rst_b) // RULE8
    (bus_wr || bus_rd) && flash_hit && st_reg.acc == FRA_ACC_IDLE |=> !acc_done ##1 acc_done)
    else $error("flash access not two states");

  a_variant_read: assert property (@(posedge mclk) disable iff (!rst_b) // RULE9
    !HAS_FLASH && bus_rd && bus_addr == `FRA_ADDR_SYS_CTRL2 |=> bus_rdata == `FRA_UNDEF_READ)
    else $error("variant read wrong");

  a_pin_protects: assert property (@(posedge mclk) disable iff (!rst_b) // RULE10
    !hw_permit |=> !flash_prog_en && !flash_erase_en)
    else $error("program or erase without permit pin");

  a_erase_blocks: assert property (@(posedge mclk) disable iff (!rst_b) // RULE14
    flash_erase_en |-> erase_fill == 8'hFF && erase_block_mask == {st_reg.erase_sel2,
    st_reg.erase_sel1})
    else $error("erase not whole block or fill wrong");
endmodule // fra_top

// ===== tb/fra_host_model.sv
`timescale 1ns/10ps
// ==================================================================
// Programming host and board pins
module fra_host_model (
  input  wire logic       mclk,
  input  wire logic [2:0] mode_req,
  input  wire logic [2:0] prog_req,
  input  wire logic       permit_req,
  input  wire logic       rx_bit,
  input  wire logic       serial_out_ch1,
  output logic            flash_write_permit,
  output logic      [2:0] mode_pins,
  output logic      [2:0] prog_pins,
  output logic            serial_in_ch1,
  output logic            tx_seen
);
  // Board pull levels before the host takes over
  initial begin
    flash_write_permit = 1'h0;
    mode_pins = 3'h7;
    prog_pins = 3'h0;
    serial_in_ch1 = 1'h1;
    tx_seen = 1'h1;
  end
  // pins move only after an edge
  // host sends on receive pin, samples transmit pin
  always @(posedge mclk) begin
    mode_pins <= mode_req;
    prog_pins <= prog_req;
    flash_write_permit <= permit_req;
    serial_in_ch1 <= rx_bit;
    tx_seen <= serial_out_ch1;
  end
endmodule // fra_host_model

// ===== tb/tb_fra_top.sv
`timescale 1ns/10ps
`include "fra_consts.svh"
module tb_fra_top;
  import fra_pkg::*;
  logic        mclk = 1'h0;
  logic        rst_b, bus_wr, bus_rd, bus_wide, sci_tx_data, permit_req, rx_bit;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, nf_seen;
  logic [2:0]  mode_req, prog_req;
  wire logic [7:0]  bus_rdata, nf_rdata, erase_fill;
  wire logic        acc_done, serial_out_ch1, sci_rx_data, flash_prog_en, flash_erase_en;
  wire logic        flash_write_permit, serial_in_ch1, tx_seen;
  wire logic [15:0] erase_block_mask;
  wire logic [5:0]  op_mode_code;
  wire logic [2:0]  mode_pins, prog_pins;
  int          err_count, total_checks, cycles;

  always #50 mclk = ~mclk;

  fra_host_model host (.mclk, .mode_req, .prog_req, .permit_req, .rx_bit, .serial_out_ch1,
    .flash_write_permit, .mode_pins, .prog_pins, .serial_in_ch1, .tx_seen);
  fra_top dut (.mclk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_wide, .bus_rdata,
    .acc_done, .flash_write_permit, .op_mode_pin_2(mode_pins[2]), .op_mode_pin_1(mode_pins[1]),
    .op_mode_pin_0(mode_pins[0]), .programmer_mode_pin_c(prog_pins[2]),
    .programmer_mode_pin_b(prog_pins[1]), .programmer_mode_pin_a(prog_pins[0]),
    .serial_in_ch1, .serial_out_ch1, .sci_tx_data, .sci_rx_data, .flash_prog_en,
    .flash_erase_en, .erase_block_mask, .erase_fill, .op_mode_code);
  // Variant without reprogrammable flash, same stimulus
  fra_top #(.HAS_FLASH(1'b0)) dut_nf (.mclk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_wide, .bus_rdata(nf_rdata), .acc_done(), .flash_write_permit,
    .op_mode_pin_2(mode_pins[2]), .op_mode_pin_1(mode_pins[1]), .op_mode_pin_0(mode_pins[0]),
    .programmer_mode_pin_c(prog_pins[2]), .programmer_mode_pin_b(prog_pins[1]),
    .programmer_mode_pin_a(prog_pins[0]), .serial_in_ch1, .serial_out_ch1(), .sci_tx_data,
    .sci_rx_data(), .flash_prog_en(), .flash_erase_en(), .erase_block_mask(), .erase_fill(),
    .op_mode_code());

  // ==================================================================
  // Checking and verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ceiling well above the two hundred or so cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done;
    end
  end

  // ==================================================================
  // Bus cycles, entered and left at a rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge mclk);
    bus_wr <= 1'h0;
    @(posedge mclk);
  endtask

  // Also checks the one-cycle data window and the second-state pulse
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic done);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge mclk);
    bus_rd <= 1'h0;
    @(negedge mclk);
    chk(bus_rdata, exp);
    nf_seen = nf_rdata;
    @(negedge mclk);
    chk(bus_rdata, 8'h00);
    chk(acc_done, done);
    @(posedge mclk);
  endtask

  // Pin effects need host delay plus synchroniser plus state
  task automatic idle;
    repeat (6) @(posedge mclk);
  endtask

  // ==================================================================
  // Sequence
  initial begin
    rst_b = 1'h0;
    {bus_wr, bus_rd, bus_wide, sci_tx_data, rx_bit} = 5'h00;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    mode_req = 3'h7;
    prog_req = 3'h0;
    permit_req = 1'h1;
    repeat (5) @(posedge mclk);
    rst_b <= 1'h1;
    idle;
    rd(`FRA_ADDR_SYS_CTRL2, 8'h00, 1'h0);
    rd(`FRA_ADDR_RAM_EMU, 8'h00, 1'h0);
    rd(`FRA_ADDR_FL_CTRL1, 8'h00, 1'h0);
    wr(`FRA_ADDR_RAM_EMU, 8'h5A);
    rd(`FRA_ADDR_RAM_EMU, 8'h5A, 1'h0);
    wr(`FRA_ADDR_SYS_CTRL2, 8'h08);
    rd(`FRA_ADDR_SYS_CTRL2, 8'h08, 1'h0);
    chk(nf_seen, `FRA_UNDEF_READ);
    rd(`FRA_ADDR_FL_CTRL1, 8'h80, 1'h1);
    rd(16'h1234, 8'h00, 1'h0);
    wr(`FRA_ADDR_FL_CTRL2, 8'h3C);
    rd(`FRA_ADDR_FL_CTRL2, 8'h00, 1'h1);
    bus_wide <= 1'h1;
    wr(`FRA_ADDR_FL_CTRL1, 8'h40);
    rd(`FRA_ADDR_FL_CTRL1, 8'h00, 1'h0);
    bus_wide <= 1'h0;
    rd(`FRA_ADDR_FL_CTRL1, 8'h80, 1'h1);
    wr(`FRA_ADDR_FL_CTRL1, 8'h40);
    wr(`FRA_ADDR_FL_CTRL2, 8'h3C);
    wr(`FRA_ADDR_ERASE_SEL1, 8'h81);
    wr(`FRA_ADDR_ERASE_SEL2, 8'h02);
    rd(`FRA_ADDR_FL_CTRL2, 8'h3C, 1'h1);
    rd(`FRA_ADDR_ERASE_SEL2, 8'h02, 1'h1);
    wr(`FRA_ADDR_FL_CTRL1, 8'h42);
    rd(`FRA_ADDR_FL_CTRL1, 8'hC2, 1'h1);
    chk(flash_erase_en, 1'h1);
    chk(erase_block_mask, 16'h0281);
    chk(erase_fill, `FRA_ERASED_BYTE);
    // program only after the erase pass above
    wr(`FRA_ADDR_FL_CTRL1, 8'h41);
    rd(`FRA_ADDR_FL_CTRL1, 8'hC1, 1'h1);
    chk({flash_prog_en, flash_erase_en, erase_fill}, 10'h200);
    chk(erase_block_mask, 16'h0000);
    permit_req <= 1'h0;
    idle;
    @(negedge mclk);
    chk(flash_prog_en, 1'h0);
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      rd(`FRA_ADDR_FL_CTRL1 + 16'(i), 8'h00, 1'h1);
    end
    wr(`FRA_ADDR_FL_CTRL1, 8'h40);
    rd(`FRA_ADDR_FL_CTRL1, 8'h00, 1'h1);
    permit_req <= 1'h1;
    sci_tx_data <= 1'h0;
    // Commit lands on the edge the pin is first seen high; bit 7 still reads 0
    repeat (2) @(posedge mclk);
    wr(`FRA_ADDR_FL_CTRL1, 8'h40);
    rd(`FRA_ADDR_FL_CTRL1, 8'h80, 1'h1);
    // Writes in flash-off modes must not reach control one
    for (int m = 0; m < 8; m++) begin
      mode_req <= 3'(m);
      prog_req <= ~3'(m);
      idle;
      chk(op_mode_code, {~3'(m), 3'(m)});
      chk(serial_out_ch1, fra_on(3'(m)) ? 1'h0 : 1'h1);
      if (m == 6) begin
        rd(`FRA_ADDR_FL_CTRL1, 8'hC0, 1'h1);
      end
      wr(`FRA_ADDR_FL_CTRL1, 8'h40 | 8'(m));
      rd(`FRA_ADDR_FL_CTRL1, fra_on(3'(m)) ? 8'hC0 | 8'(m) : 8'h00, 1'h1);
    end
    // each level crosses channel one both ways, host pins included
    for (int b = 0; b < 2; b++) begin
      sci_tx_data <= b[0];
      rx_bit <= b[0];
      idle;
      chk({serial_out_ch1, sci_rx_data, tx_seen}, {3{b[0]}});
    end
    test_done;
  end

  function automatic logic fra_on(input logic [2:0] m);
    return m == `FRA_MODE_PROGRAMMER || m == `FRA_MODE_ROM_EXP || m == `FRA_MODE_ROM_SINGLE;
  endfunction
endmodule // tb_fra_top
